// File: rtl/ailc_top.sv
`timescale 1ns/1ps
// What this block does
// - decimate via CIC, two half-bands, droop compensation, high-pass, in order
// - master clock 12 or 24 MHz; rate code picks the divisor
// - envelope averaging coefficient is two to minus speed exponent
// - channel select: 00 off, 01 right, 10 left, 11 both
// - gain falls when envelope above reference, rises otherwise
// - attack field sets fall rate, decay field sets rise rate
// - during decay the gain holds for the hold time first
// - gain clamped to ceiling above and floor below
// - noise gate enabled by one bit, acts below threshold
// - gate action: 00 keep gain, 01 hard mute, 10 soft mute
// - manual gain scales high-pass output by 1, 1.25, 1.5, 1.75
// - shift field 8 passes unshifted; above shifts left, below right
// - top bit of manual register clear selects analog microphone path
module ailc_top
	import ailc_pkg::*;
#(
	parameter int HPF_K = 8
)
(
	input wire logic pclk, // system clock, 50 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [15:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic adc_valid, // one converter sample per master clock
	input wire logic signed [15:0] adc_right, // right channel sample
	input wire logic signed [15:0] adc_left, // left channel sample
	output logic out_valid, // one-cycle output sample strobe
	output logic signed [15:0] out_right, // processed right sample
	output logic signed [15:0] out_left // processed left sample
);

	typedef struct packed {
		logic [7:0] manual;
		logic [7:0] speed;
		logic [7:0] rate;
		logic [7:0] enable;
		logic [7:0] refc;
		logic [7:0] chan;
		logic [7:0] rates;
		logic [7:0] gate;
		logic [7:0] floor_r;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic [11:0] tick_cnt;
		logic [5:0] stage_v;
		logic [15:0] sample_cnt;
		ailc_chan_type [1:0] ch;
	} ailc_top_type;

	ailc_top_type r;
	ailc_top_type n;

	logic run;
	logic [15:0] rate_entry;
	logic [11:0] divisor;
	logic [3:0] norm_shift;
	logic hit;
	logic [31:0] rd_val;
	logic signed [15:0] adc_in [2];
	logic signed [31:0] acc;
	logic signed [31:0] tmp;
	logic signed [31:0] prod;
	logic [3:0] shift_f;
	logic [1:0] gain_f;
	logic [1:0] alc_v;
	logic signed [15:0] alc_data [2];
	logic [3:0] alc_gain [2];
	logic [15:0] alc_env [2];
	logic [1:0] alc_gate;

	assign adc_in[0] = adc_right;
	assign adc_in[1] = adc_left;

	// chain runs only with codec enable and clock enable both set
	assign run = r.enable[EN_CODEC_BIT] & r.rate[RATE_CLKEN_BIT];
	// divisor from rate code, doubled for the 24 MHz master clock
	assign rate_entry = rate_table(r.rate[RATE_CODE_LSB +: 5]);
	assign divisor = r.enable[EN_HALF_BIT] ? {rate_entry[10:0], 1'b0}
		: rate_entry[11:0];
	assign norm_shift = rate_entry[15:12] + {3'h0, r.enable[EN_HALF_BIT]};
	assign shift_f = r.manual[MAN_SHIFT_LSB +: 4];
	assign gain_f = r.manual[MAN_GAIN_LSB +: 2];

	// register read decode
	always_comb
	begin
		hit = 1'b1;
		rd_val = 32'h0;
		case (paddr)
			byte_addr(IDX_MANUAL): rd_val = {24'h0, r.manual};
			byte_addr(IDX_SPEED): rd_val = {24'h0, r.speed};
			byte_addr(IDX_RATE): rd_val = {24'h0, r.rate};
			byte_addr(IDX_ENABLE): rd_val = {24'h0, r.enable};
			byte_addr(IDX_REF): rd_val = {24'h0, r.refc};
			byte_addr(IDX_CHAN): rd_val = {24'h0, r.chan};
			byte_addr(IDX_RATES): rd_val = {24'h0, r.rates};
			byte_addr(IDX_GATE): rd_val = {24'h0, r.gate};
			byte_addr(IDX_FLOOR): rd_val = {24'h0, r.floor_r};
			byte_addr(IDX_STATUS):
				rd_val = {21'h0, run, alc_gate, alc_gain[1], alc_gain[0]};
			byte_addr(IDX_COUNT): rd_val = {16'h0, r.sample_cnt};
			byte_addr(IDX_ENVELOPE): rd_val = {alc_env[1], alc_env[0]};
			default:
			begin
				hit = 1'b0;
				rd_val = 32'h0;
			end
		endcase
	end

	always_comb
	begin
		n = r;
		acc = 32'sh0;
		tmp = 32'sh0;
		prod = 32'sh0;

		// bus answers in the first access cycle
		n.pready = 1'b0;
		n.pslverr = 1'b0;
		if (psel && !penable)
		begin
			n.pready = 1'b1;
			n.pslverr = !hit;
			n.prdata = pwrite ? 32'h0 : rd_val;
		end
		if (psel && penable && r.pready && pwrite && hit)
		begin
			case (paddr)
				byte_addr(IDX_MANUAL): n.manual = pwdata[7:0];
				byte_addr(IDX_SPEED): n.speed = pwdata[7:0];
				byte_addr(IDX_RATE): n.rate = pwdata[7:0];
				byte_addr(IDX_ENABLE): n.enable = pwdata[7:0];
				byte_addr(IDX_REF): n.refc = pwdata[7:0];
				byte_addr(IDX_CHAN): n.chan = pwdata[7:0];
				byte_addr(IDX_RATES): n.rates = pwdata[7:0];
				byte_addr(IDX_GATE): n.gate = pwdata[7:0];
				byte_addr(IDX_FLOOR): n.floor_r = pwdata[7:0];
				// status, count and envelope are read only
				default: n.enable = r.enable;
			endcase
		end

		// one strobe walks down the stages, one stage per cycle
		n.stage_v = {r.stage_v[4:0], 1'b0};

		if (!run)
		begin
			// stopping the chain drops a partial decimation window
			n.tick_cnt = 12'h0;
			n.stage_v = 6'h0;
			for (int i = 0; i < 2; i++)
				n.ch[i].integ = 32'sh0;
		end
		else if (adc_valid)
		begin
			if (r.tick_cnt == divisor - 12'h1)
			begin
				n.tick_cnt = 12'h0;
				n.stage_v[0] = 1'b1;
			end
			else
				n.tick_cnt = r.tick_cnt + 12'h1;
		end

		for (int i = 0; i < 2; i++)
		begin
			// CIC integrate and dump over one output period
			if (run && adc_valid)
			begin
				acc = r.ch[i].integ + 32'(adc_in[i]);
				if (r.tick_cnt == divisor - 12'h1)
				begin
					n.ch[i].cic = sat18(acc >>> norm_shift);
					n.ch[i].integ = 32'sh0;
				end
				else
					n.ch[i].integ = acc;
			end
			if (r.stage_v[0])
			begin
				tmp = 32'(r.ch[i].cic) + (32'(r.ch[i].cic_d1) <<< 1)
					+ 32'(r.ch[i].cic_d2);
				n.ch[i].hb1 = sat18(tmp >>> 2);
				n.ch[i].cic_d1 = r.ch[i].cic;
				n.ch[i].cic_d2 = r.ch[i].cic_d1;
			end
			if (r.stage_v[1])
			begin
				tmp = 32'(r.ch[i].hb1) + (32'(r.ch[i].hb1_d1) <<< 1)
					+ 32'(r.ch[i].hb1_d2);
				n.ch[i].hb2 = sat18(tmp >>> 2);
				n.ch[i].hb1_d1 = r.ch[i].hb1;
				n.ch[i].hb1_d2 = r.ch[i].hb1_d1;
			end
			// droop compensation lifts the top of the band
			if (r.stage_v[2])
			begin
				tmp = (32'(r.ch[i].hb2) <<< 1) - 32'(r.ch[i].hb2_d1)
					- 32'(r.ch[i].hb2_d2);
				n.ch[i].drp = sat18(32'(r.ch[i].hb2) + (tmp >>> 3));
				n.ch[i].hb2_d1 = r.ch[i].hb2;
				n.ch[i].hb2_d2 = r.ch[i].hb2_d1;
			end
			// high-pass: subtract a slow running mean
			if (r.stage_v[3])
			begin
				tmp = 32'(r.ch[i].drp) - (r.ch[i].hpf_dc >>> HPF_K);
				n.ch[i].hpf = sat18(tmp);
				n.ch[i].hpf_dc = r.ch[i].hpf_dc + tmp;
			end
			if (r.stage_v[4])
			begin
				// manual stage only on the analog microphone path
				if (!r.manual[MAN_PATH_BIT])
				begin
					// gain of one plus a quarter per step
					prod = 32'(r.ch[i].hpf)
						+ ((32'(r.ch[i].hpf) * $signed({30'h0, gain_f})) >>> 2);
					if (shift_f >= SHIFT_UNITY)
						prod = prod <<< (shift_f - SHIFT_UNITY);
					else
						prod = prod >>> (SHIFT_UNITY - shift_f);
					n.ch[i].man = sat16(prod);
				end
				else
					n.ch[i].man = sat16(32'(r.ch[i].hpf));
			end
		end

		if (r.stage_v[5])
			n.sample_cnt = r.sample_cnt + 16'h1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.manual <= RST_REG;
			r.speed <= RST_REG;
			r.rate <= RST_REG;
			r.enable <= RST_REG;
			r.refc <= RST_REG;
			r.chan <= RST_REG;
			r.rates <= RST_REG;
			r.gate <= RST_REG;
			r.floor_r <= RST_REG;
		end
		else
			r <= n;
	end

	// channel 0 is right, channel 1 is left
	for (genvar g = 0; g < 2; g++)
	begin : g_alc
		ailc_alc u_alc (
			.pclk(pclk),
			.presetn(presetn),
			.in_valid(r.stage_v[5]),
			.in_data(r.ch[g].man),
			// select bit per channel switches level control
			.alc_on(r.chan[CHAN_SEL_LSB + g]),
			.env_k(r.speed[ENV_K_LSB +: 4]),
			.ref_lvl(r.refc[REF_LSB +: 4]),
			.ceiling(r.refc[CEIL_LSB +: 4]),
			.floor_lvl(r.floor_r[FLOOR_LSB +: 3]),
			.gain_attack_rate(r.rates[ATK_LSB +: 4]),
			.gain_decay_rate(r.rates[DCY_LSB +: 4]),
			.hold(r.chan[HOLD_LSB +: 4]),
			.gate_en(r.gate[GATE_EN_BIT]),
			.gate_act(r.gate[GATE_ACT_LSB +: 2]),
			.gate_thr(r.gate[GATE_THR_LSB +: 5]),
			.out_valid(alc_v[g]),
			.out_data(alc_data[g]),
			.gain_level(alc_gain[g]),
			.envelope(alc_env[g]),
			.gate_active(alc_gate[g])
		);
	end

	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
	// both channels are strobed together, so either strobe will do
	assign out_valid = alc_v[0];
	assign out_right = alc_data[0];
	assign out_left = alc_data[1];

endmodule : ailc_top

// File: rtl/ailc_pkg.sv
package ailc_pkg;

	// register indices; the byte address on the bus is four times the index
	localparam logic [11:0] IDX_MANUAL = 12'hb12;
	localparam logic [11:0] IDX_SPEED = 12'hb85;
	localparam logic [11:0] IDX_RATE = 12'hb8a;
	localparam logic [11:0] IDX_ENABLE = 12'hb8b;
	localparam logic [11:0] IDX_REF = 12'hba0;
	localparam logic [11:0] IDX_CHAN = 12'hba1;
	localparam logic [11:0] IDX_RATES = 12'hba2;
	localparam logic [11:0] IDX_GATE = 12'hba3;
	localparam logic [11:0] IDX_FLOOR = 12'hba4;
	localparam logic [11:0] IDX_STATUS = 12'hba8;
	localparam logic [11:0] IDX_COUNT = 12'hba9;
	localparam logic [11:0] IDX_ENVELOPE = 12'hbaa;

	// field positions
	localparam int MAN_GAIN_LSB = 0;
	localparam int MAN_SHIFT_LSB = 2;
	localparam int MAN_PATH_BIT = 7;
	localparam int ENV_K_LSB = 4;
	localparam int RATE_CLKEN_BIT = 0;
	localparam int RATE_CODE_LSB = 1;
	localparam int RATE_MODE_LSB = 6;
	localparam int EN_CODEC_BIT = 1;
	localparam int EN_HALF_BIT = 2;
	localparam int REF_LSB = 0;
	localparam int CEIL_LSB = 4;
	localparam int HOLD_LSB = 0;
	localparam int CHAN_SEL_LSB = 5;
	localparam int ATK_LSB = 0;
	localparam int DCY_LSB = 4;
	localparam int GATE_EN_BIT = 0;
	localparam int GATE_ACT_LSB = 1;
	localparam int GATE_THR_LSB = 3;
	localparam int FLOOR_LSB = 0;

	// reset values
	localparam logic [7:0] RST_REG = 8'h00;
	localparam logic [3:0] GAIN_RESET = 4'h7;

	// arithmetic constants
	localparam logic [3:0] SHIFT_UNITY = 4'h8;
	localparam logic [1:0] GATE_KEEP = 2'h0;
	localparam logic [1:0] GATE_HARD = 2'h1;
	localparam logic [1:0] GATE_SOFT = 2'h2;
	localparam logic [3:0] SOFT_ATT_MAX = 4'hf;

	typedef struct packed {
		logic signed [31:0] integ;
		logic signed [17:0] cic;
		logic signed [17:0] cic_d1;
		logic signed [17:0] cic_d2;
		logic signed [17:0] hb1;
		logic signed [17:0] hb1_d1;
		logic signed [17:0] hb1_d2;
		logic signed [17:0] hb2;
		logic signed [17:0] hb2_d1;
		logic signed [17:0] hb2_d2;
		logic signed [17:0] drp;
		logic signed [31:0] hpf_dc;
		logic signed [17:0] hpf;
		logic signed [15:0] man;
	} ailc_chan_type;

	typedef struct packed {
		logic [15:0] env;
		logic [3:0] gain;
		logic [15:0] rate_cnt;
		logic [15:0] hold_cnt;
		logic [3:0] soft_att;
		logic gate_on;
		logic out_valid;
		logic signed [15:0] out_data;
	} ailc_alc_type;

	function automatic logic [15:0] byte_addr(input logic [11:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : byte_addr

	// master clock divisor and normalising shift for each rate code
	function automatic logic [15:0] rate_table(input logic [4:0] code);
		logic [15:0] v;
		v = {4'h8, 12'h0fa};
		case (code)
			5'h06, 5'h04: v = {4'hb, 12'h5dc};
			5'h17, 5'h15: v = {4'hb, 12'h5d8};
			5'h19: v = {4'hb, 12'h440};
			5'h08: v = {4'ha, 12'h3e8};
			5'h0a: v = {4'ha, 12'h2ee};
			5'h1b: v = {4'ha, 12'h220};
			5'h1c: v = {4'h9, 12'h1f4};
			5'h0c: v = {4'h9, 12'h177};
			5'h13, 5'h11: v = {4'h9, 12'h110};
			5'h02, 5'h00: v = {4'h8, 12'h0fa};
			5'h1f: v = {4'h8, 12'h088};
			5'h0e: v = {4'h7, 12'h07d};
			default: v = {4'h8, 12'h0fa};
		endcase
		return v;
	endfunction : rate_table

	function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
		if (x > 32'sh00007fff)
			return 16'sh7fff;
		else if (x < -32'sh00008000)
			return 16'sh8000;
		else
			return x[15:0];
	endfunction : sat16

	function automatic logic signed [17:0] sat18(input logic signed [31:0] x);
		if (x > 32'sh0001ffff)
			return 18'sh1ffff;
		else if (x < -32'sh00020000)
			return 18'sh20000;
		else
			return x[17:0];
	endfunction : sat18

endpackage : ailc_pkg

// File: rtl/ailc_alc.sv
`timescale 1ns/1ps
module ailc_alc
	import ailc_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	input wire logic in_valid, // one sample this cycle
	input wire logic signed [15:0] in_data, // sample after manual stage
	input wire logic alc_on, // level control acts on this channel
	input wire logic [3:0] env_k, // envelope speed exponent
	input wire logic [3:0] ref_lvl, // level reference
	input wire logic [3:0] ceiling, // gain ceiling
	input wire logic [2:0] floor_lvl, // gain floor
	input wire logic [3:0] gain_attack_rate, // attack rate
	input wire logic [3:0] gain_decay_rate, // decay rate
	input wire logic [3:0] hold, // hold time
	input wire logic gate_en, // noise gate enable
	input wire logic [1:0] gate_act, // noise gate action
	input wire logic [4:0] gate_thr, // noise gate threshold
	output logic out_valid, // one-cycle sample strobe
	output logic signed [15:0] out_data, // regulated sample
	output logic [3:0] gain_level, // current gain step
	output logic [15:0] envelope, // detected envelope
	output logic gate_active // gate closed on last sample
);

	ailc_alc_type r;
	ailc_alc_type n;
	logic [15:0] mag;
	logic signed [31:0] diff;
	logic signed [31:0] scaled;
	logic gate;
	logic over;

	always_comb
	begin
		n = r;
		mag = in_data[15] ? 16'(-in_data) : in_data;
		diff = 32'sh0;
		scaled = 32'sh0;
		gate = 1'b0;
		over = 1'b0;
		n.out_valid = in_valid;
		if (in_valid)
		begin
			diff = $signed({16'h0, mag}) - $signed({16'h0, r.env});
			n.env = 16'(32'(r.env) + (diff >>> env_k));
			gate = gate_en && (r.env < {1'b0, gate_thr, 10'h0});
			over = r.env > {ref_lvl, 12'h0};
			n.gate_on = gate;
			if (alc_on && !(gate && gate_act == GATE_KEEP))
			begin
				if (over)
				begin
					n.hold_cnt = 16'h0;
					n.rate_cnt = r.rate_cnt + 16'h1;
					if (r.rate_cnt >= (16'h1 << gain_attack_rate))
					begin
						n.rate_cnt = 16'h0;
						if (r.gain != 4'h0)
							n.gain = r.gain - 4'h1;
					end
				end
				else if (r.hold_cnt < (16'h1 << hold))
				begin
					n.hold_cnt = r.hold_cnt + 16'h1;
					n.rate_cnt = 16'h0;
				end
				else
				begin
					n.rate_cnt = r.rate_cnt + 16'h1;
					if (r.rate_cnt >= (16'h1 << gain_decay_rate))
					begin
						n.rate_cnt = 16'h0;
						if (r.gain != 4'hf)
							n.gain = r.gain + 4'h1;
					end
				end
				if (n.gain < {1'b0, floor_lvl})
					n.gain = {1'b0, floor_lvl};
				if (n.gain > ceiling)
					n.gain = ceiling;
			end
			// gain steps are eighths, step seven is unity
			if (alc_on)
				scaled = (32'(in_data) * $signed({28'h0, n.gain} + 32'h1)) >>> 3;
			else
				scaled = 32'(in_data);
			if (gate && gate_act == GATE_SOFT)
			begin
				if (r.soft_att != SOFT_ATT_MAX)
					n.soft_att = r.soft_att + 4'h1;
			end
			else if (r.soft_att != 4'h0)
				n.soft_att = r.soft_att - 4'h1;
			if (gate && gate_act == GATE_HARD)
				n.out_data = 16'sh0;
			else
				n.out_data = sat16(scaled >>> n.soft_att);
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			r <= '0;
			r.gain <= GAIN_RESET;
		end
		else
			r <= n;
	end

	assign out_valid = r.out_valid;
	assign out_data = r.out_data;
	assign gain_level = r.gain;
	assign envelope = r.env;
	assign gate_active = r.gate_on;

endmodule : ailc_alc

// File: sim/ailc_adc_model.sv
`timescale 1ns/1ps
module ailc_adc_model
(
	input wire logic pclk, // system clock
	input wire logic presetn, // reset, active low
	input wire logic run, // send one sample each cycle
	output logic adc_valid, // sample strobe
	output logic signed [15:0] adc_right, // right sample
	output logic signed [15:0] adc_left // left sample
);
	logic [10:0] t_r;
	// square wave: a level the high-pass keeps for the regulator to see
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			t_r <= 11'h0;
			adc_valid <= 1'b0;
			adc_right <= 16'sh0;
			adc_left <= 16'sh0;
		end
		else
		begin
			t_r <= t_r + 11'h1;
			adc_valid <= run;
			// idle lines toggle so no stale sample looks valid
			adc_right <= !run ? ~adc_right : t_r[10] ? 16'sh4e20 : -16'sh4e20;
			adc_left <= !run ? ~adc_left : t_r[10] ? 16'sh4e20 : -16'sh4e20;
		end
	end
endmodule : ailc_adc_model

// File: sim/ailc_assertions.sv
`timescale 1ns/1ps
module ailc_chk
	import ailc_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic presetn, // reset, active low
	input wire logic psel, // select
	input wire logic penable, // access phase
	input wire logic pwrite, // write
	input wire logic [15:0] paddr, // byte address
	input wire logic [31:0] pwdata, // write data
	input wire logic [31:0] prdata, // read data
	input wire logic pready, // ready
	input wire logic pslverr, // error
	input wire logic adc_valid, // sample strobe
	input wire logic signed [15:0] adc_right, // right in
	input wire logic signed [15:0] adc_left, // left in
	input wire logic out_valid, // output strobe
	input wire logic signed [15:0] out_right, // right out
	input wire logic signed [15:0] out_left // left out
);
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic cfg_hit;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_answer;
		psel && penable && pready;
	endsequence
	// cycles since the last sample; the pipeline is shorter than 9
	always_comb
	begin
		quiet_nxt = quiet_r;
		if (adc_valid)
			quiet_nxt = 4'h0;
		else if (quiet_r != 4'hf)
			quiet_nxt = quiet_r + 4'h1;
		cfg_hit = paddr[15:14] == 2'h0 && paddr[1:0] == 2'h0
			&& paddr[13:2] >= IDX_REF && paddr[13:2] <= IDX_FLOOR;
	end
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			quiet_r <= 4'hf;
		else
			quiet_r <= quiet_nxt;
	end
	a_zero_wait: assert property (s_setup |=> s_answer)
		else $error("no zero-wait answer");
	a_ready_once: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	a_err_quiet: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error without ready or with data");
	a_cfg_no_err: assert property (pready && cfg_hit |-> !pslverr)
		else $error("error on a mapped register");
	a_cfg_byte_wide: assert property (
		pready && !pwrite && cfg_hit |-> prdata[31:8] == 24'h0)
		else $error("upper read bits set");
	a_strobe_pulse: assert property (out_valid |=> !out_valid)
		else $error("output strobe too long");
	a_data_held: assert property (
		$changed(out_right) || $changed(out_left) |-> out_valid)
		else $error("output changed without strobe");
	a_out_has_cause: assert property (out_valid |-> quiet_r <= 4'h8)
		else $error("output without recent sample");
	c_output: cover property (out_valid);
endmodule : ailc_chk
bind ailc_top ailc_chk ailc_chk_inst (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.adc_valid(adc_valid), .adc_right(adc_right), .adc_left(adc_left),
	.out_valid(out_valid), .out_right(out_right), .out_left(out_left));

// File: sim/tb.sv
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
	begin \
		n_compared++; \
		if ((gt) !== (ex)) \
		begin \
			n_mismatch++; \
			$display("mismatch %s exp %h got %h", nm, ex, gt); \
		end \
	end
module tb
	import ailc_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [15:0] paddr = 16'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic adc_valid;
	logic signed [15:0] adc_right;
	logic signed [15:0] adc_left;
	logic out_valid;
	logic signed [15:0] out_right;
	logic signed [15:0] out_left;
	logic run = 1'b0;
	logic [31:0] rd;
	logic err;
	int n_mismatch = 0;
	int n_compared = 0;
	int n_out = 0;
	int n_tot = 0;
	int cyc = 0;
	int last = 0;
	int gap = 0;
	logic [11:0] idx [9] = '{IDX_MANUAL, IDX_SPEED, IDX_RATE, IDX_ENABLE,
		IDX_REF, IDX_CHAN, IDX_RATES, IDX_GATE, IDX_FLOOR};
	logic [4:0] cd [4] = '{5'h1f, 5'h0e, 5'h0e, 5'h0a};
	logic hv [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
	int dv [4] = '{136, 125, 250, 750};
	always #10 pclk = ~pclk;
	always @(posedge pclk)
	begin
		cyc++;
		if (out_valid === 1'b1)
		begin
			n_out++;
			n_tot++;
			gap = cyc - last;
			last = cyc;
		end
	end
	ailc_top #(.HPF_K(8)) ailc_top_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .adc_valid(adc_valid), .adc_right(adc_right),
		.adc_left(adc_left), .out_valid(out_valid),
		.out_right(out_right), .out_left(out_left));
	ailc_adc_model ailc_adc_model_inst (.pclk(pclk), .presetn(presetn),
		.run(run), .adc_valid(adc_valid), .adc_right(adc_right),
		.adc_left(adc_left));
	task automatic results;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : results
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= {2'h0, a, 2'h0};
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1)
		begin
			n_mismatch++;
			results();
		end
	endtask : apb
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [11:0] a, input logic [31:0] e,
		input string nm);
		apb(1'b0, a, 32'h0);
		`CHK(nm, e, rd)
	endtask : rdc
	// third strobe proves a steady spacing, not the start-up one
	task automatic measure(input int d);
		int k;
		k = 0;
		n_out = 0;
		while (n_out < 3 && k < 4 * d + 200)
		begin
			@(posedge pclk);
			k++;
		end
		`CHK("gap", d, gap)
	endtask : measure
	initial
	begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rdc(idx[i], 32'h0, "reset");
		rdc(IDX_STATUS, 32'h77, "status reset");
		for (int i = 0; i < 9; i++)
			wr(idx[i], {24'hffffff, 8'ha5 ^ 8'(i)});
		for (int i = 0; i < 9; i++)
			rdc(idx[i], {24'h0, 8'ha5 ^ 8'(i)}, "reg rw");
		for (int i = 0; i < 9; i++)
			wr(idx[i], 32'h0);
		apb(1'b0, 12'h000, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		wr(IDX_STATUS, 32'hff);
		rdc(IDX_STATUS, 32'h77, "status ro");
		run <= 1'b1;
		wr(IDX_ENABLE, 32'h2);
		repeat (400) @(posedge pclk);
		wr(IDX_ENABLE, 32'h0);
		wr(IDX_RATE, 32'h3f);
		repeat (400) @(posedge pclk);
		`CHK("idle out", 0, n_tot)
		for (int i = 0; i < 4; i++)
		begin
			wr(IDX_RATE, 32'h0);
			repeat (20) @(posedge pclk);
			wr(IDX_ENABLE, {29'h0, hv[i], 2'h2});
			wr(IDX_RATE, {24'h0, 2'h1, cd[i], 1'b1});
			measure(dv[i]);
		end
		rdc(IDX_STATUS, 32'h477, "status run");
		wr(IDX_RATE, 32'h0);
		repeat (20) @(posedge pclk);
		n_out = 0;
		rdc(IDX_COUNT, 32'(n_tot), "count");
		repeat (900) @(posedge pclk);
		`CHK("stopped", 0, n_out)
		wr(IDX_REF, 32'hf0);
		wr(IDX_FLOOR, 32'h2);
		wr(IDX_CHAN, 32'h20);
		wr(IDX_ENABLE, 32'h2);
		wr(IDX_RATE, 32'h1d);
		repeat (8000) @(posedge pclk);
		rdc(IDX_STATUS, 32'h472, "right at floor");
		wr(IDX_REF, 32'h5f);
		repeat (8000) @(posedge pclk);
		rdc(IDX_STATUS, 32'h475, "right at ceiling");
		wr(IDX_GATE, 32'hfb);
		repeat (3000) @(posedge pclk);
		apb(1'b0, IDX_STATUS, 32'h0);
		`CHK("gate on", 1'b1, rd[8])
		`CHK("hard mute", 16'sh0, out_right)
		`CHK("left gate on", 1'b1, rd[9])
		`CHK("left hard mute", 16'sh0, out_left)
		results();
	end
endmodule : tb
